// ===== core/mdl_pkg.sv
// Purpose: shared constants for the motor duty limiter and error response
// Assumes: 32-bit APB register words, byte addresses
// Notes: duty is signed -600..600, error variable signed -4095..4095
package mdl_pkg;
	localparam int DUTY_W = 11;
	localparam logic signed [10:0] DUTY_MAX = 11'sd600;
	localparam int ERR_W = 13;
	localparam int NUM_ERR = 13;
	localparam logic signed [12:0] CTRL_ERR_MAX = 13'sd4095;
	// Error bit positions
	localparam int EB_AWAIT = 0;
	localparam int EB_NOPWR = 1;
	localparam int EB_DRV = 2;
	localparam int EB_INVAL = 3;
	localparam int EB_INDIS = 4;
	localparam int EB_FBDIS = 5;
	localparam int EB_OVC = 6;
	localparam int EB_SER_FRAME = 7;
	localparam int EB_SER_OVR = 8;
	localparam int EB_SER_RXFULL = 9;
	localparam int EB_SER_CRC = 10;
	localparam int EB_SER_PROTO = 11;
	localparam int EB_SER_TMO = 12;
	// Response policy codes
	typedef enum logic [1:0] {
		MDL_RESP_OFF = 2'b00,
		MDL_RESP_ON = 2'b01,
		MDL_RESP_LATCH = 2'b10
	} mdl_resp_type;
	// Register offsets
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_MAXDUTY = 8'h04;
	localparam logic [7:0] A_MAXACC = 8'h08;
	localparam logic [7:0] A_BRAKE = 8'h0c;
	localparam logic [7:0] A_MAXCUR = 8'h10;
	localparam logic [7:0] A_CAL = 8'h14;
	localparam logic [7:0] A_OORDUTY = 8'h18;
	localparam logic [7:0] A_RESP = 8'h1c;
	localparam logic [7:0] A_ERRNOW = 8'h20;
	localparam logic [7:0] A_ERROCC = 8'h24;
	localparam logic [7:0] A_DUTY = 8'h28;
	localparam logic [7:0] A_CURRENT = 8'h2c;
	localparam logic [7:0] A_PERIOD = 8'h30;
	localparam logic [7:0] A_IRQST = 8'h34;
	localparam logic [7:0] A_IRQMSK = 8'h38;
	localparam logic [7:0] A_CNTSEL = 8'h3c;
	// CTRL bits
	localparam int C_ASYM = 0;
	localparam int C_COAST = 1;
	localparam int C_RESTART = 2;
	localparam int C_MOTOR_OFF = 3;
	localparam int C_DRV_COAST = 4;
	// Reset values
	localparam logic [31:0] R_MAXDUTY = 32'h0258_0258;
	localparam logic [31:0] R_MAXACC = 32'h0258_0258;
	localparam logic [31:0] R_CAL = 32'h0000_2525;
	localparam logic [31:0] R_OORDUTY = 32'h0000_0258;
	localparam logic [25:0] R_RESP = 26'h155_5555;
	localparam logic [15:0] R_PERIOD = 16'h2710;
	// Brake duration counts in ms
	localparam int MS_NS = 1000000;
	localparam int CLK_NS = 10;
	localparam int MS_CYC = MS_NS / CLK_NS;
endpackage

// ===== core/mdl_err_cnt.sv
// Purpose: one occurrence counter for an error flag
// Assumes: flag is synchronous to clk
// Notes: counts rising edges, saturates, clears on request
`timescale 1ns/10ps
`default_nettype none
module mdl_err_cnt #(
	parameter int W = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic flag,
	input wire logic clear,
	output logic [W-1:0] count
);
	logic flag_d;

	// Edge memory
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			flag_d <= 1'b0;
		else
			flag_d <= flag;
	end

	// Saturating count; a new occurrence beats the clear unless the count is saturated, then the clear wins
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			count <= '0;
		else if (flag && !flag_d && count != '1)
			count <= clear ? W'(1) : count + W'(1);
		else if (clear)
			count <= '0;
	end
endmodule
`default_nettype wire

// ===== core/mdl_sat.sv
// Purpose: signed magnitude clamp used by two limit stages
// Assumes: lim is non-negative
// Notes: purely combinational
`timescale 1ns/10ps
`default_nettype none
module mdl_sat (
	input wire logic signed [12:0] din,
	input wire logic signed [12:0] lim,
	output logic signed [12:0] dout
);
	// Clamp both signs to the same magnitude
	always_comb
	begin
		if (din > lim)
			dout = lim;
		else if (din < -lim)
			dout = -lim;
		else
			dout = din;
	end
endmodule
`default_nettype wire

// ===== core/mdl_top.sv
// Purpose: duty limiter, off-state and error response for one DC motor
// Assumes: APB slave, 100 MHz clk, error and feedback inputs off-chip
// Notes: drive outputs are per-pin levels with enables for coast
// Behaviour
// - Duty is signed, -600 to +600
// - Asymmetric option gives separate per-direction limits
// - Clamp magnitude to direction's maximum duty
// - Limit per-period change to maximum acceleration
// - Reduce duty while current exceeds configured maximum
// - Current reported as 8-bit raw, times calibration
// - Hold zero for brake duration before reversing; dwell only when one step crosses zero, none after landing on zero
// - Forward dwell for fwd-to-rev, reverse otherwise
// - Reduced cap while feedback out of range
// - Motor off brakes or coasts as configured
// - Variant picks brake or coast at zero duty
// - Thirteen one-hot error flags, fixed bit order
// - Each error has three response settings
// - Disabled errors still recorded and counted
// - Enabled errors stop motor while present
// - Latched errors stop motor, set awaiting flag
// - Latched stop held until target or restart
// - Control error variable signed -4095 to 4095
//
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module mdl_top
	import mdl_pkg::*;
#(
	parameter int PWM_W = 10,
	parameter int CNT_W = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic signed [10:0] duty_target,
	input wire logic signed [12:0] ctrl_error,
	input wire logic [7:0] current_raw,
	input wire logic feedback_out_of_range,
	input wire logic [12:1] error_cond,
	input wire logic set_target_cmd,
	output logic signed [12:0] ctrl_error_q,
	output logic signed [10:0] duty,
	output logic motor_a,
	output logic motor_a_oe,
	output logic motor_b,
	output logic motor_b_oe,
	output logic motor_running,
	output logic irq
);
	import mdl_pkg::*;

	logic [31:0] ctrl, max_duty, max_acc, brake_ms, max_cur, cal;
	logic [31:0] oor_duty;
	logic [25:0] resp;
	logic [15:0] period;
	logic [3:0] cnt_sel;
	logic [NUM_ERR-1:0] err_now, err_occ, err_clr_occ, stop_now;
	logic [NUM_ERR-1:0] irq_st, irq_msk;
	logic [CNT_W-1:0] occ_cnt [NUM_ERR];
	logic [15:0] per_cnt;
	logic tick, await_latch, occ_clr_cnt;
	logic [7:0] cur_s1, cur_s2;
	logic oor_s1, oor_s2;
	logic [12:1] econd_s1, econd_s2;
	logic [PWM_W-1:0] pwm_cnt;
	logic [31:0] ms_cnt;
	logic [15:0] brake_left;
	logic wr;
	logic motor_off;

	assign wr = psel && penable && pwrite;
	assign pready = 1'b1;
	// Addresses above A_CNTSEL flagged, not silently ignored
	always_comb
	begin
		pslverr = 1'b0;
		if (psel && penable && paddr > A_CNTSEL)
			pslverr = 1'b1;
	end

	// Off-chip inputs through two flops
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cur_s1 <= 8'h00;
			cur_s2 <= 8'h00;
			oor_s1 <= 1'b0;
			oor_s2 <= 1'b0;
			econd_s1 <= 12'h000;
			econd_s2 <= 12'h000;
		end
		else
		begin
			cur_s1 <= current_raw;
			cur_s2 <= cur_s1;
			oor_s1 <= feedback_out_of_range;
			oor_s2 <= oor_s1;
			econd_s1 <= error_cond;
			econd_s2 <= econd_s1;
		end
	end

	// Register writes
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ctrl <= 32'h0000_0000;
			max_duty <= R_MAXDUTY;
			max_acc <= R_MAXACC;
			brake_ms <= 32'h0000_0000;
			max_cur <= 32'h0000_0000;
			cal <= R_CAL;
			oor_duty <= R_OORDUTY;
			resp <= R_RESP;
			period <= R_PERIOD;
			irq_msk <= '0;
			cnt_sel <= 4'h0;
		end
		else
		begin
			ctrl[C_RESTART] <= 1'b0; // Self-clearing restart strobe
			if (wr)
			begin
				case (paddr)
					A_CTRL: ctrl <= pwdata;
					A_MAXDUTY: max_duty <= pwdata;
					A_MAXACC: max_acc <= pwdata;
					A_BRAKE: brake_ms <= pwdata;
					A_MAXCUR: max_cur <= pwdata;
					A_CAL: cal <= pwdata;
					A_OORDUTY: oor_duty <= pwdata;
					A_RESP: resp <= pwdata[25:0];
					A_PERIOD: period <= pwdata[15:0];
					A_IRQMSK: irq_msk <= pwdata[NUM_ERR-1:0];
					A_CNTSEL: cnt_sel <= pwdata[3:0];
					default: ;
				endcase
			end
		end
	end

	// Per-direction setting: low half forward, high half reverse
	function automatic logic signed [12:0] pick(input logic [31:0] r,
		input logic rev, input logic asym);
		logic [15:0] h;
		h = (rev && asym) ? r[31:16] : r[15:0];
		pick = $signed({1'b0, h[11:0]});
	endfunction

	// Control period divider
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			per_cnt <= 16'h0000;
		else if (per_cnt >= period)
			per_cnt <= 16'h0000;
		else
			per_cnt <= per_cnt + 16'h0001;
	end
	assign tick = (per_cnt == period);

	// Millisecond divider for the brake dwell
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			ms_cnt <= 32'h0;
		else if (ms_cnt == 32'(MS_CYC - 1))
			ms_cnt <= 32'h0;
		else
			ms_cnt <= ms_cnt + 32'h1;
	end

	// Error flags: bit 0 is the latched awaiting-command state
	logic [NUM_ERR-1:0] latch_hit;
	always_comb
	begin
		err_now = {econd_s2, await_latch};
		stop_now = '0;
		latch_hit = '0;
		for (int i = 0; i < NUM_ERR; i++)
		begin
			if (err_now[i] && resp[2*i +: 2] == MDL_RESP_ON)
				stop_now[i] = 1'b1;
			if (err_now[i] && resp[2*i +: 2] == MDL_RESP_LATCH)
			begin
				stop_now[i] = 1'b1;
				latch_hit[i] = 1'b1;
			end
		end
	end

	// Latched stop waits for a target command or restart
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			await_latch <= 1'b1;
		else if (|latch_hit[NUM_ERR-1:1])
			await_latch <= 1'b1;
		else if (set_target_cmd || ctrl[C_RESTART])
			await_latch <= 1'b0;
	end

	// Occurred flags; set beats clear
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			err_occ <= '0;
		else
			err_occ <= (err_occ & ~err_clr_occ) | err_now;
	end
	assign err_clr_occ = (wr && paddr == A_ERROCC) ?
		pwdata[NUM_ERR-1:0] : '0;
	assign occ_clr_cnt = wr && paddr == A_CNTSEL && pwdata[31];

	// Occurrence counters, one per flag
	genvar g;
	generate
		for (g = 0; g < NUM_ERR; g++)
		begin : g_cnt
			mdl_err_cnt #(.W(CNT_W)) u_cnt (
				.clk(clk),
				.rst(rst),
				.flag(err_now[g]),
				.clear(occ_clr_cnt),
				.count(occ_cnt[g])
			);
		end
	endgenerate

	// Sticky interrupt status, write one to clear, set wins
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			irq_st <= '0;
		else if (wr && paddr == A_IRQST)
			irq_st <= (irq_st & ~pwdata[NUM_ERR-1:0]) | (err_now & ~err_occ);
		else
			irq_st <= irq_st | (err_now & ~err_occ);
	end
	assign irq = |(irq_st & irq_msk);

	assign motor_off = (|stop_now) || ctrl[C_MOTOR_OFF];

	// Limit chain, evaluated combinationally from the held duty
	logic rev_t, rev_d, asym;
	logic signed [12:0] d_prev, d_tgt, acc_lim, step, d_acc;
	logic signed [12:0] cap, d_cap, d_cur, d_fin;
	logic [15:0] cur_ma;
	assign asym = ctrl[C_ASYM];
	assign d_prev = 13'(duty);
	assign d_tgt = 13'(duty_target);
	assign rev_t = d_tgt < 0;
	assign acc_lim = pick(max_acc, rev_t, asym);
	assign step = d_tgt - d_prev;
	mdl_sat u_acc (.din(step), .lim(acc_lim), .dout(d_acc));
	assign rev_d = (d_prev + d_acc) < 0;
	assign cap = oor_s2 ? pick(oor_duty, rev_d, 1'b0)
		: pick(max_duty, rev_d, asym);
	mdl_sat u_cap (.din(d_prev + d_acc), .lim(cap), .dout(d_cap));
	assign cur_ma = 16'(cur_s2 * (rev_d && asym ? cal[15:8] : cal[7:0]));

	// Over-limit current backs off one step from the held duty, so
	// a far target cannot keep pushing it up through acceleration
	always_comb
	begin
		d_cur = d_cap;
		if (pick(max_cur, rev_d, asym) != 0 &&
			cur_ma > 16'(pick(max_cur, rev_d, asym)))
		begin
			if (d_prev > 0)
				d_cur = (d_cap < d_prev) ? d_cap : d_prev - 13'sd1;
			else if (d_prev < 0)
				d_cur = (d_cap > d_prev) ? d_cap : d_prev + 13'sd1;
			else
				d_cur = 13'sd0;
		end
	end

	// Brake dwell: a sign change first parks at zero
	always_comb
	begin
		d_fin = d_cur;
		if ((d_prev > 0 && d_cur < 0) || (d_prev < 0 && d_cur > 0) ||
			(brake_left != 16'h0 && d_cur != 0 && d_prev == 0))
			d_fin = 13'sd0;
		if (d_fin > 13'(DUTY_MAX))
			d_fin = 13'(DUTY_MAX);
		else if (d_fin < -13'(DUTY_MAX))
			d_fin = -13'(DUTY_MAX);
	end

	// Dwell countdown in milliseconds
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			brake_left <= 16'h0;
		else if (tick && d_prev > 0 && d_cur < 0)
			brake_left <= brake_ms[15:0];
		else if (tick && d_prev < 0 && d_cur > 0)
			brake_left <= (asym ? brake_ms[31:16] : brake_ms[15:0]);
		else if (ms_cnt == 32'h0 && brake_left != 16'h0)
			brake_left <= brake_left - 16'h1;
	end

	// Duty register, updated once per period; motor off zeroes it in any cycle
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			duty <= 11'sd0;
		else if (motor_off)
			duty <= 11'sd0;
		else if (tick)
			duty <= 11'(d_fin);
	end

	// Error variable sampled for reporting
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			ctrl_error_q <= 13'sd0;
		else if (tick)
			ctrl_error_q <= (ctrl_error > CTRL_ERR_MAX) ? CTRL_ERR_MAX :
				(ctrl_error < -CTRL_ERR_MAX) ? -CTRL_ERR_MAX
				: ctrl_error;
	end

	// PWM carrier, 600 steps per cycle
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			pwm_cnt <= '0;
		else if (pwm_cnt == PWM_W'(DUTY_MAX - 11'sd1))
			pwm_cnt <= '0;
		else
			pwm_cnt <= pwm_cnt + PWM_W'(1);
	end

	// Bridge pins; low-side level is ground, no oe means floating
	logic on_ph;
	logic [9:0] mag;
	assign mag = duty < 0 ? 10'(-duty) : 10'(duty);
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			motor_a <= 1'b0;
			motor_b <= 1'b0;
			motor_a_oe <= 1'b0;
			motor_b_oe <= 1'b0;
			motor_running <= 1'b0;
		end
		else
		begin
			motor_running <= !motor_off;
			if (motor_off)
			begin
				motor_a <= 1'b0;
				motor_b <= 1'b0;
				motor_a_oe <= !ctrl[C_COAST];
				motor_b_oe <= !ctrl[C_COAST];
			end
			else if (on_ph)
			begin
				motor_a <= duty > 0;
				motor_b <= duty < 0;
				motor_a_oe <= 1'b1;
				motor_b_oe <= 1'b1;
			end
			else
			begin
				motor_a <= 1'b0;
				motor_b <= 1'b0;
				motor_a_oe <= !ctrl[C_DRV_COAST];
				motor_b_oe <= !ctrl[C_DRV_COAST];
			end
		end
	end
	assign on_ph = PWM_W'(mag) > pwm_cnt;

	// Read mux, registered
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			prdata <= 32'h0;
		else if (psel && !penable && !pwrite)
		begin
			case (paddr)
				A_CTRL: prdata <= ctrl;
				A_MAXDUTY: prdata <= max_duty;
				A_MAXACC: prdata <= max_acc;
				A_BRAKE: prdata <= brake_ms;
				A_MAXCUR: prdata <= max_cur;
				A_CAL: prdata <= cal;
				A_OORDUTY: prdata <= oor_duty;
				A_RESP: prdata <= {6'h0, resp};
				A_ERRNOW: prdata <= {3'h0, stop_now, 3'h0, err_now};
				A_ERROCC: prdata <= {19'h0, err_occ};
				A_DUTY: prdata <= {{21{duty[10]}}, duty};
				A_CURRENT: prdata <= {cur_ma, 8'h0, cur_s2};
				A_PERIOD: prdata <= {16'h0, period};
				A_IRQST: prdata <= {19'h0, irq_st};
				A_IRQMSK: prdata <= {19'h0, irq_msk};
				A_CNTSEL: prdata <= (cnt_sel < 4'(NUM_ERR)) ?
					32'(occ_cnt[cnt_sel]) : 32'h0;
				default: prdata <= 32'h0;
			endcase
		end
	end
endmodule
`default_nettype wire

// ===== dv/mdl_motor_model.sv
// Purpose: H-bridge and brush motor seen from the drive pins
// Assumes: pins sampled on clk, current in raw 8-bit steps
// Notes: current climbs while driven, decays while braking or coasting
`timescale 1ns/10ps
`default_nettype none
module mdl_motor_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic motor_a,
	input wire logic motor_a_oe,
	input wire logic motor_b,
	input wire logic motor_b_oe,
	output logic [7:0] current_raw
);
	// Raw current saturates at full scale, never wraps
	always_ff @(posedge clk or posedge rst)
		if (rst)
			current_raw <= 8'h00;
		else if ((motor_a & motor_a_oe) ^ (motor_b & motor_b_oe))
			current_raw <= current_raw + 8'(current_raw != 8'hff);
		else
			current_raw <= current_raw >> 1;
endmodule
`default_nettype wire

// ===== dv/mdl_monitor.sv
// Purpose: port checks for the motor duty limiter
// Assumes: one clock, rst async active high
// Notes: register contents are not visible here
`timescale 1ns/10ps
`default_nettype none
module mdl_monitor
	import mdl_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic signed [12:0] ctrl_error_q,
	input wire logic signed [10:0] duty,
	input wire logic motor_a,
	input wire logic motor_a_oe,
	input wire logic motor_b,
	input wire logic motor_b_oe,
	input wire logic motor_running,
	input wire logic irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// A stop held long enough for registered outputs to follow
	sequence s_off;
		!motor_running [*3];
	endsequence
	sequence s_bad_rd;
		psel && !penable && !pwrite && paddr > A_CNTSEL;
	endsequence
	sequence s_unmask;
		psel && penable && pwrite && paddr == A_IRQMSK && pwdata == 0;
	endsequence
	property p_rst_idle;
		$fell(rst) |-> duty == 0 && !motor_a_oe && !motor_b_oe;
	endproperty
	property p_duty_rng;
		duty <= DUTY_MAX && duty >= -DUTY_MAX;
	endproperty
	property p_err_rng;
		ctrl_error_q <= CTRL_ERR_MAX && ctrl_error_q >= -CTRL_ERR_MAX;
	endproperty
	property p_off_zero;
		s_off |-> duty == 0;
	endproperty
	property p_off_pins;
		s_off |-> !(motor_a && motor_a_oe) && !(motor_b && motor_b_oe);
	endproperty
	property p_bad_rd;
		s_bad_rd |=> prdata == 0 && pslverr;
	endproperty
	property p_unmask;
		s_unmask |=> !irq;
	endproperty
	property p_good_addr;
		psel && penable && paddr <= A_CNTSEL |-> !pslverr;
	endproperty
	a_rst_idle: assert property (p_rst_idle)
		else $error("outputs not idle after reset");
	a_duty_rng: assert property (p_duty_rng)
		else $error("duty out of range");
	a_err_rng: assert property (p_err_rng)
		else $error("control error out of range");
	a_off_zero: assert property (p_off_zero)
		else $error("duty not zero while off");
	a_off_pins: assert property (p_off_pins)
		else $error("pin driven high while off");
	a_bad_rd: assert property (p_bad_rd)
		else $error("unmapped read not refused");
	a_unmask: assert property (p_unmask)
		else $error("irq high with mask clear");
	a_good_addr: assert property (p_good_addr)
		else $error("mapped access refused");
endmodule
bind mdl_top mdl_monitor i_mdl_monitor (
	.clk(clk), .rst(rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pslverr(pslverr), .ctrl_error_q(ctrl_error_q), .duty(duty),
	.motor_a(motor_a), .motor_a_oe(motor_a_oe), .motor_b(motor_b),
	.motor_b_oe(motor_b_oe), .motor_running(motor_running), .irq(irq)
);
`default_nettype wire

// ===== dv/tb_mdl_top.sv
// Purpose: self-checking bench for the motor duty limiter
// Assumes: APB master tasks, motor model on the far side
// Notes: period register cut to 20 (21 cycles), brake dwell left at zero
`timescale 1ns/10ps
`default_nettype none
module tb_mdl_top;
	import mdl_pkg::*;
	logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
	logic oor = 0, stc = 0, serr, pready, pslverr, irq, run;
	logic ma, mao, mb, mbo;
	logic [7:0] paddr = 8'h00, cur;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic signed [10:0] tgt = 11'h0, duty;
	logic signed [12:0] cerr = 13'h0, ceq;
	logic [12:1] ec = 12'h0;
	logic [7:0] ra [5] = '{A_MAXDUTY, A_MAXACC, A_CAL, A_OORDUTY, 8'h40};
	logic [31:0] rv [5] = '{R_MAXDUTY, R_MAXACC, R_CAL, R_OORDUTY, 0};
	int n_errors = 0, tests_run = 0, seed = 32'h297b, e = 0;
	mdl_top i_mdl_top (.clk(clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .duty_target(tgt), .ctrl_error(cerr),
		.current_raw(cur), .feedback_out_of_range(oor),
		.error_cond(ec), .set_target_cmd(stc), .ctrl_error_q(ceq),
		.duty(duty), .motor_a(ma), .motor_a_oe(mao), .motor_b(mb),
		.motor_b_oe(mbo), .motor_running(run), .irq(irq));
	mdl_motor_model i_mdl_motor_model (.clk(clk), .rst(rst),
		.motor_a(ma), .motor_a_oe(mao), .motor_b(mb),
		.motor_b_oe(mbo), .current_raw(cur));
	// 100 MHz clock
	initial
		forever #5 clk = ~clk;
	task chk(input string n, input logic [31:0] s, input logic [31:0] x);
		tests_run++;
		if (s !== x)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, x, s);
		end
	endtask
	// One APB transfer, held until pready is seen high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		q = prdata;
		serr = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge clk);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1, a, d);
	endtask
	task rd(input logic [7:0] a);
		apb(0, a, 32'h0);
	endtask
	task automatic wt(ref logic s, input logic v);
		int k;
		k = 0;
		while (s !== v && k < 500)
		begin
			@(posedge clk);
			k++;
		end
	endtask
	// Model steps one period at a time: acceleration, then clamp
	task automatic ramp(input int t, input int lf, input int lr);
		int n;
		tgt <= 11'(t);
		forever
		begin
			n = t - e;
			n = e + (n > 50 ? 50 : n < -50 ? -50 : n);
			n = n > lf ? lf : n < -lr ? -lr : n;
			if (n == e)
				return;
			while (duty === 11'(e))
				@(posedge clk);
			cerr <= 13'($random(seed) % 4096);
			chk("duty", duty, n);
			e = n;
		end
	endtask
	task test_done;
		$display("tests_run %0d n_errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Hang guard, far beyond the thousand or so cycles needed
	initial
	begin
		#300us;
		n_errors++;
		test_done;
	end
	initial
	begin
		repeat (8) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		foreach (ra[i])
		begin
			rd(ra[i]);
			chk("reset", q, rv[i]);
		end
		chk("slverr", serr, 1);
		rd(A_ERRNOW);
		chk("await", q[EB_AWAIT], 1);
		chk("run", run, 0);
		$display("test reset done");
		// Asymmetric limits: forward 250, reverse 200, step 50
		wr(A_PERIOD, 32'h14);
		wr(A_CTRL, 32'h1);
		wr(A_MAXDUTY, 32'h00c8_00fa);
		wr(A_MAXACC, 32'h0032_0032);
		wr(A_MAXCUR, 32'h0);
		wr(A_OORDUTY, 32'h64);
		tgt <= 11'(300 + ($random(seed) & 255));
		stc <= 1;
		@(posedge clk);
		stc <= 0;
		ramp(tgt, 250, 200);
		oor <= 1;
		ramp(tgt, 100, 100);
		oor <= 0;
		ramp(-600, 250, 200);
		// Full reverse so the bridge current settles at full scale
		wr(A_MAXDUTY, 32'h0258_00fa);
		ramp(-600, 250, 600);
		repeat (300) @(posedge clk);
		rd(A_CURRENT);
		chk("current_ma", q[31:16], 32'(q[7:0]) * R_CAL[7:0]);
		// One mA limit: each period backs off by one
		wr(A_MAXCUR, 32'h0001_0001);
		repeat (3)
		begin
			while (duty === 11'(e))
				@(posedge clk);
			chk("cur_limit", duty, e + 1);
			e = e + 1;
		end
		wr(A_MAXCUR, 32'h0);
		// Error variable passed through, then clamped
		cerr <= 13'($random(seed) % 4096);
		repeat (25) @(posedge clk);
		chk("ctrl_err", ceq, cerr);
		cerr <= 13'h1000;
		repeat (25) @(posedge clk);
		chk("ctrl_err", ceq, -4095);
		$display("test limits done");
		// Enabled error stops the motor only while present
		ec[EB_DRV] <= 1;
		wt(run, 0);
		chk("run", run, 0);
		ec[EB_DRV] <= 0;
		wt(run, 1);
		chk("run", run, 1);
		// Disabled error still counted and flagged
		wr(A_RESP, 32'(R_RESP & ~(26'h3 << 6)));
		wr(A_IRQMSK, 32'h8);
		ec[EB_INVAL] <= 1;
		wt(irq, 1);
		rd(A_ERROCC);
		chk("occurred", q[EB_INVAL], 1);
		chk("run", run, 1);
		wr(A_CNTSEL, 32'h3);
		rd(A_CNTSEL);
		chk("count", q, 1);
		wr(A_IRQMSK, 32'h0);
		chk("irq", irq, 0);
		wr(A_IRQMSK, 32'h8);
		chk("irq", irq, 1);
		wr(A_IRQST, 32'h8);
		chk("irq", irq, 0);
		ec[EB_INVAL] <= 0;
		// Latched error keeps the motor off until a new target
		wr(A_RESP, 32'(R_RESP ^ (26'h3 << 12)));
		ec[EB_OVC] <= 1;
		wt(run, 0);
		ec[EB_OVC] <= 0;
		repeat (100) @(posedge clk);
		rd(A_ERRNOW);
		chk("await", q[EB_AWAIT], 1);
		chk("run", run, 0);
		stc <= 1;
		@(posedge clk);
		stc <= 0;
		wt(run, 1);
		chk("run", run, 1);
		// Second latched stop, released by the restart strobe
		ec[EB_OVC] <= 1;
		wt(run, 0);
		ec[EB_OVC] <= 0;
		repeat (4) @(posedge clk);
		wr(A_CTRL, 32'h5);
		wt(run, 1);
		chk("restart", run, 1);
		$display("test errors done");
		// Motor off: brake first, then coast
		tgt <= 11'sd0;
		wr(A_CTRL, 32'h9);
		wt(run, 0);
		repeat (2) @(posedge clk);
		chk("brake", {ma, mao, mb, mbo}, 4'h5);
		wr(A_CTRL, 32'hb);
		wt(mao, 0);
		chk("coast", {mao, mbo}, 2'h0);
		// Zero duty while running: brake or coast by variant
		wr(A_CTRL, 32'h1);
		wt(run, 1);
		repeat (2) @(posedge clk);
		chk("zero_brake", {ma, mao, mb, mbo}, 4'h5);
		wr(A_CTRL, 32'h11);
		repeat (2) @(posedge clk);
		chk("zero_coast", {mao, mbo}, 2'h0);
		$display("test off state done");
		test_done;
	end
endmodule
`default_nettype wire
